// ---- rtc_pkg.sv ----
// Constants, field layouts and carrier types for the clock status block
package rtc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h01;
  localparam logic [7:0] ADDR_SECONDS  = 8'h02;
  localparam logic [7:0] ADDR_MINUTES  = 8'h03;
  localparam logic [7:0] ADDR_HOURS    = 8'h04;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_PULSE_BIT = 4;
  localparam int CTRL_AF_BIT    = 3;
  localparam int CTRL_TF_BIT    = 2;
  localparam int CTRL_AIE_BIT   = 1;
  localparam int CTRL_TIE_BIT   = 0;
  localparam int SEC_VL_BIT     = 7;

  // ****************************************
  // Reset values and BCD limits
  // ****************************************
  localparam logic [4:0] CTRL_RESET    = 5'h00;
  localparam logic       VL_RESET      = 1'b1;
  localparam logic [7:0] SECONDS_RESET = 8'h00;
  localparam logic [7:0] MINUTES_RESET = 8'h00;
  localparam logic [7:0] HOURS_RESET   = 8'h00;
  localparam logic [7:0] SEC_MAX       = 8'h59;
  localparam logic [7:0] MIN_MAX       = 8'h59;
  localparam logic [7:0] HOUR_MAX      = 8'h23;
  localparam logic [7:0] SEC_MASK      = 8'h7F;
  localparam logic [7:0] MIN_MASK      = 8'h7F;
  localparam logic [7:0] HOUR_MASK     = 8'h3F;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_HZ       = 40_000_000;
  localparam int TICK_HZ        = 1;
  localparam int PULSE_HZ_8192  = 8192;
  localparam int PULSE_HZ_4096  = 4096;
  localparam int PULSE_HZ_128   = 128;
  localparam int PULSE_HZ_64    = 64;
  localparam int SECOND_CYC     = CLOCK_HZ / TICK_HZ;
  localparam int PULSE_CYC_8192 = CLOCK_HZ / PULSE_HZ_8192;
  localparam int PULSE_CYC_4096 = CLOCK_HZ / PULSE_HZ_4096;
  localparam int PULSE_CYC_128  = CLOCK_HZ / PULSE_HZ_128;
  localparam int PULSE_CYC_64   = CLOCK_HZ / PULSE_HZ_64;
  localparam int WIDTH_BITS     = 20;
  localparam int TICK_BITS      = 26;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {SRC_4096_HZ, SRC_64_HZ, SRC_1_HZ, SRC_1_60_HZ} timer_src_t;

  typedef struct packed {
    logic pulse_mode;
    logic alarm_flag;
    logic timer_flag;
    logic alarm_irq_enable;
    logic timer_irq_enable;
  } irq_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;

endpackage : rtc_pkg

// ---- irq_pulse_gen.sv ----
// Interrupt pulse stretcher for the countdown timer events
`timescale 1ns/1ps
`default_nettype none

module irq_pulse_gen #(
  parameter int WIDTH_BITS = rtc_pkg::WIDTH_BITS
) (
  input  wire logic                  clock,
  input  wire logic                  rst_sync_b,
  input  wire logic                  start,
  input  wire logic [WIDTH_BITS-1:0] width,
  output logic                       busy
);

  logic [WIDTH_BITS-1:0] remain;
  logic [WIDTH_BITS-1:0] next_remain;

  // Start cycle itself is the first pulse cycle, so load one less
  always_comb begin
    next_remain = remain;
    if (start) begin
      next_remain = (width == '0) ? '0 : width - 1'b1;
    end else if (remain != '0) begin
      next_remain = remain - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      remain <= '0;
    end else begin
      remain <= next_remain;
    end
  end

  assign busy = (remain != '0);

endmodule : irq_pulse_gen

`default_nettype wire

// ---- rtc_irq_time.sv ----
// Interrupt control/status, integrity flag and seconds/minutes/hours counters
// What this block does
// - Level mode: interrupt follows enabled timer flag.
// - Pulse mode: width set by source, count.
// - Enabled alarm flag holds interrupt active always.
// - Bit 3 reads alarm flag; zero clears.
// - Bit 2 reads timer flag; zero clears.
// - Enables gate alarm and timer onto interrupt.
// - Alarm match and timer end set flags.
// - Flags stay set until host clears them.
// - Write ANDs each flag with written bit.
// - Interrupt is OR of enabled conditions.
// - Timer flag and pulse start together.
// - Zero loaded count stops timer events.
// - Seconds bit 7 shows integrity, one at start.
// - Supply low or oscillator stop sets it.
// - Only host write clears integrity flag.
// - Seconds BCD 00 to 59.
// - Minutes BCD, tens 0 to 5.
// - Hours BCD, tens 0 to 2.
// - Time counting frozen during host access.
// - One pending second kept during access.
`timescale 1ns/1ps
`default_nettype none

module rtc_irq_time #(
  parameter int SECOND_CYC     = rtc_pkg::SECOND_CYC,
  parameter int PULSE_CYC_8192 = rtc_pkg::PULSE_CYC_8192,
  parameter int PULSE_CYC_4096 = rtc_pkg::PULSE_CYC_4096,
  parameter int PULSE_CYC_128  = rtc_pkg::PULSE_CYC_128,
  parameter int PULSE_CYC_64   = rtc_pkg::PULSE_CYC_64
) (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire rtc_pkg::reg_req_t   reg_req,
  input  wire logic                access_active,
  output logic [7:0]               rd_data,
  input  wire logic                alarm_match,
  input  wire logic                timer_end,
  input  wire rtc_pkg::timer_src_t timer_src,
  input  wire logic [7:0]          timer_count_n,
  input  wire logic                supply_low,
  input  wire logic                osc_stopped,
  output logic                     int_o,
  output logic                     int_oe
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_pipe;
  logic       rst_sync_b;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe[1];

  // ****************************************
  // Detector pins, three stages
  // ****************************************
  logic [1:0] det_s1, det_s2, det_s3;
  logic [1:0] det_level;

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      det_s1    <= 2'h0;
      det_s2    <= 2'h0;
      det_s3    <= 2'h0;
      det_level <= 2'h0;
    end else begin
      det_s1 <= {osc_stopped, supply_low};
      det_s2 <= det_s1;
      det_s3 <= det_s2;
      for (int i = 0; i < 2; i++) begin
        if (det_s2[i] == det_s3[i]) begin
          det_level[i] <= det_s3[i];
        end
      end
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Returns {wrap, next value}; writes at or above max wrap to 00 on next increment
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] max);
    logic [8:0] r;
    r = {1'b0, v};
    if (v >= max) begin
      r = {1'b1, 8'h00};
    end else if (v[3:0] >= 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction : bcd_inc

  function automatic logic [rtc_pkg::WIDTH_BITS-1:0] cyc(input int n);
    return n[rtc_pkg::WIDTH_BITS-1:0];
  endfunction : cyc

  logic wr_ctrl, wr_sec, wr_min, wr_hour;
  assign wr_ctrl = reg_req.wr && (reg_req.addr == rtc_pkg::ADDR_IRQ_CTRL);
  assign wr_sec  = reg_req.wr && (reg_req.addr == rtc_pkg::ADDR_SECONDS);
  assign wr_min  = reg_req.wr && (reg_req.addr == rtc_pkg::ADDR_MINUTES);
  assign wr_hour = reg_req.wr && (reg_req.addr == rtc_pkg::ADDR_HOURS);

  // ****************************************
  // Interrupt control and output
  // ****************************************
  rtc_pkg::irq_ctrl_t ctrl, next_ctrl;
  logic next_int_oe;
  logic timer_hit;
  logic pulse_start;
  logic pulse_busy;
  logic [rtc_pkg::WIDTH_BITS-1:0] pulse_width;

  assign timer_hit = timer_end && (timer_count_n != 8'h00);

  always_comb begin
    case (timer_src)
      rtc_pkg::SRC_4096_HZ: pulse_width = (timer_count_n == 8'h01) ? cyc(PULSE_CYC_8192)
                                                                  : cyc(PULSE_CYC_4096);
      rtc_pkg::SRC_64_HZ:   pulse_width = (timer_count_n == 8'h01) ? cyc(PULSE_CYC_128)
                                                                  : cyc(PULSE_CYC_64);
      default:              pulse_width = cyc(PULSE_CYC_64);
    endcase
  end

  always_comb begin
    next_ctrl = ctrl;
    // Upper three data bits are not stored; host keeps them zero
    if (wr_ctrl) begin
      next_ctrl.pulse_mode       = reg_req.data[rtc_pkg::CTRL_PULSE_BIT];
      next_ctrl.alarm_flag       = ctrl.alarm_flag & reg_req.data[rtc_pkg::CTRL_AF_BIT];
      next_ctrl.timer_flag       = ctrl.timer_flag & reg_req.data[rtc_pkg::CTRL_TF_BIT];
      next_ctrl.alarm_irq_enable = reg_req.data[rtc_pkg::CTRL_AIE_BIT];
      next_ctrl.timer_irq_enable = reg_req.data[rtc_pkg::CTRL_TIE_BIT];
    end
    // Set beats a clear arriving in the same cycle
    if (alarm_match) begin
      next_ctrl.alarm_flag = 1'b1;
    end
    if (timer_hit) begin
      next_ctrl.timer_flag = 1'b1;
    end
    pulse_start = timer_hit && next_ctrl.pulse_mode && next_ctrl.timer_irq_enable;
    // Computed from next state so flag and pin move on one edge
    next_int_oe = (next_ctrl.alarm_flag && next_ctrl.alarm_irq_enable)
                | (next_ctrl.pulse_mode
                   ? (next_ctrl.timer_irq_enable && (pulse_start || pulse_busy))
                   : (next_ctrl.timer_flag && next_ctrl.timer_irq_enable));
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl   <= rtc_pkg::CTRL_RESET;
      int_oe <= 1'b0;
      int_o  <= 1'b0;
    end else begin
      ctrl   <= next_ctrl;
      int_oe <= next_int_oe;
      int_o  <= 1'b0;
    end
  end

  irq_pulse_gen #(
    .WIDTH_BITS (rtc_pkg::WIDTH_BITS)
  ) u_pulse (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .start      (pulse_start),
    .width      (pulse_width),
    .busy       (pulse_busy)
  );

  // ****************************************
  // One second tick and time counters
  // ****************************************
  logic [rtc_pkg::TICK_BITS-1:0] tick_cnt, next_tick_cnt;
  logic tick;
  logic pending, next_pending;
  logic vl, next_vl;
  logic [7:0] sec, min, hour;
  logic [7:0] next_sec, next_min, next_hour;
  logic [8:0] sec_inc, min_inc, hour_inc;
  logic [7:0] next_rd_data;

  assign tick = (tick_cnt == '0);

  always_comb begin
    next_tick_cnt = tick ? rtc_pkg::TICK_BITS'(SECOND_CYC - 1) : tick_cnt - 1'b1;
    next_pending  = pending;
    next_sec      = sec;
    next_min      = min;
    next_hour     = hour;
    next_vl       = vl;
    sec_inc       = bcd_inc(sec, rtc_pkg::SEC_MAX);
    min_inc       = bcd_inc(min, rtc_pkg::MIN_MAX);
    hour_inc      = bcd_inc(hour, rtc_pkg::HOUR_MAX);
    // A second tick that lands mid-access waits; a second one is lost
    if (access_active) begin
      if (tick) begin
        next_pending = 1'b1;
      end
    end else if (tick || pending) begin
      next_pending = 1'b0;
      next_sec     = sec_inc[7:0];
      if (sec_inc[8]) begin
        next_min = min_inc[7:0];
        if (min_inc[8]) begin
          next_hour = hour_inc[7:0];
        end
      end
    end
    if (wr_sec) begin
      next_sec = reg_req.data & rtc_pkg::SEC_MASK;
      next_vl  = reg_req.data[rtc_pkg::SEC_VL_BIT];
    end
    if (wr_min) begin
      next_min = reg_req.data & rtc_pkg::MIN_MASK;
    end
    if (wr_hour) begin
      next_hour = reg_req.data & rtc_pkg::HOUR_MASK;
    end
    if (det_level != 2'h0) begin
      next_vl = 1'b1;
    end
    case (reg_req.addr)
      rtc_pkg::ADDR_IRQ_CTRL: next_rd_data = {3'h0, ctrl};
      rtc_pkg::ADDR_SECONDS:  next_rd_data = {vl, sec[6:0]};
      rtc_pkg::ADDR_MINUTES:  next_rd_data = {1'b0, min[6:0]};
      rtc_pkg::ADDR_HOURS:    next_rd_data = {2'h0, hour[5:0]};
      default:                next_rd_data = 8'h00;
    endcase
    if (!reg_req.rd) begin
      next_rd_data = rd_data;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tick_cnt <= '0;
      pending  <= 1'b0;
      vl       <= rtc_pkg::VL_RESET;
      sec      <= rtc_pkg::SECONDS_RESET;
      min      <= rtc_pkg::MINUTES_RESET;
      hour     <= rtc_pkg::HOURS_RESET;
      rd_data  <= 8'h00;
    end else begin
      tick_cnt <= next_tick_cnt;
      pending  <= next_pending;
      vl       <= next_vl;
      sec      <= next_sec;
      min      <= next_min;
      hour     <= next_hour;
      rd_data  <= next_rd_data;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_sync_b);

  chk_alarm_set: assert property (alarm_match |=> ctrl.alarm_flag)
    else $error("alarm match did not set alarm flag");
  chk_flag_hold: assert property (ctrl.timer_flag && !wr_ctrl |=> ctrl.timer_flag)
    else $error("timer flag dropped without a write");
  chk_and_write: assert property (wr_ctrl && !alarm_match |=>
      ctrl.alarm_flag == ($past(ctrl.alarm_flag) && $past(reg_req.data[3])))
    else $error("alarm flag write is not an AND");
  chk_level_int: assert property (!ctrl.pulse_mode && ctrl.timer_flag && ctrl.timer_irq_enable |-> int_oe)
    else $error("level mode interrupt not active");
  chk_alarm_int: assert property (ctrl.alarm_flag && ctrl.alarm_irq_enable |-> int_oe)
    else $error("alarm interrupt not held active");
  chk_enable_gate: assert property (!ctrl.alarm_irq_enable && !ctrl.timer_irq_enable |-> !int_oe)
    else $error("interrupt active with both enables off");
  chk_pulse_start: assert property (timer_hit && !wr_ctrl && ctrl.pulse_mode && ctrl.timer_irq_enable
      |=> ctrl.timer_flag && int_oe)
    else $error("timer flag and pulse not together");
  chk_stop_zero: assert property (timer_count_n == 8'h00 && !ctrl.timer_flag |=> !ctrl.timer_flag)
    else $error("timer flag set with zero count");
  chk_vl_sticky: assert property (vl && !wr_sec |=> vl)
    else $error("integrity flag cleared without a write");
  chk_sec_range: assert property (!wr_sec |=> sec[6:4] <= 3'h5 && sec[3:0] <= 4'h9 || $past(sec) > 8'h59)
    else $error("seconds left BCD range");
  chk_freeze: assert property (access_active && !wr_sec |=> $stable(sec))
    else $error("seconds moved during access");
  chk_pending: assert property (pending && !access_active && !wr_sec
      |=> sec != $past(sec))
    else $error("pending second not applied");

endmodule : rtc_irq_time

`default_nettype wire

// ---- reg_host.sv ----
// Host side model that drives the byte register port
`timescale 1ns/1ps
`default_nettype none

module reg_host (
  input  wire logic            clock,
  input  wire logic [7:0]      rd_data,
  output var rtc_pkg::reg_req_t req,
  output var logic             access_active
);
  initial begin
    req           = '0;
    access_active = 1'b0;
  end

  // ****************************************
  // Byte transfers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req.wr   = 1'b1;
    req.addr = a;
    req.data = (a == rtc_pkg::ADDR_IRQ_CTRL) ? (d & 8'h1F) : d;
    @(negedge clock);
    req.wr   = 1'b0;
    // Released lines must not keep showing the last value
    req.data = ~req.data;
    req.addr = ~req.addr;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge clock);
    d        = rd_data;
    req.rd   = 1'b0;
    req.addr = ~req.addr;
  endtask : rd

  // Access framing; t_time holds one access open across two one-second ticks
  task automatic hold(input logic on);
    @(negedge clock);
    access_active = on;
  endtask : hold
endmodule : reg_host

`default_nettype wire

// ---- rtc_irq_time_tb.sv ----
// Self-checking testbench for the interrupt, integrity and time block
`timescale 1ns/1ps
`default_nettype none

module rtc_irq_time_tb;
  logic                clock;
  logic                rst_b;
  logic                alarm_match;
  logic                timer_end;
  logic                supply_low;
  logic                osc_stopped;
  rtc_pkg::timer_src_t timer_src;
  logic [7:0]          timer_count_n;
  logic [7:0]          rd_data;
  logic [7:0]          v;
  logic [7:0]          cnt;
  logic                int_o;
  logic                int_oe;
  logic                access_active;
  rtc_pkg::reg_req_t   reg_req;
  int                  mismatches;
  int                  cmp_count;
  // Source, loaded count and expected pulse width for the short parameters
  rtc_pkg::timer_src_t src_tab[6] = '{rtc_pkg::SRC_4096_HZ, rtc_pkg::SRC_4096_HZ, rtc_pkg::SRC_64_HZ,
                                      rtc_pkg::SRC_64_HZ, rtc_pkg::SRC_1_HZ, rtc_pkg::SRC_1_60_HZ};
  logic [7:0]          n_tab[6]   = '{8'h01, 8'h02, 8'h01, 8'h02, 8'h01, 8'h01};
  logic [7:0]          w_tab[6]   = '{8'h03, 8'h05, 8'h07, 8'h09, 8'h09, 8'h09};

  rtc_irq_time #(
    .SECOND_CYC    (50),
    .PULSE_CYC_8192(3),
    .PULSE_CYC_4096(5),
    .PULSE_CYC_128 (7),
    .PULSE_CYC_64  (9)
  ) dut_u (
    .clock        (clock),
    .rst_b        (rst_b),
    .reg_req      (reg_req),
    .access_active(access_active),
    .rd_data      (rd_data),
    .alarm_match  (alarm_match),
    .timer_end    (timer_end),
    .timer_src    (timer_src),
    .timer_count_n(timer_count_n),
    .supply_low   (supply_low),
    .osc_stopped  (osc_stopped),
    .int_o        (int_o),
    .int_oe       (int_oe)
  );

  reg_host h_u (
    .clock        (clock),
    .rd_data      (rd_data),
    .req          (reg_req),
    .access_active(access_active)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    h_u.rd(a, v);
    chk(v, exp);
  endtask : rd_chk

  task automatic fire(input logic alarm);
    @(negedge clock);
    alarm_match = alarm;
    timer_end   = !alarm;
    @(negedge clock);
    alarm_match = 1'b0;
    timer_end   = 1'b0;
  endtask : fire

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    h_u.hold(1'b1);
    rd_chk(rtc_pkg::ADDR_IRQ_CTRL, 8'h00);
    rd_chk(rtc_pkg::ADDR_SECONDS, 8'h80);
    rd_chk(rtc_pkg::ADDR_MINUTES, 8'h00);
    rd_chk(rtc_pkg::ADDR_HOURS, 8'h00);
    rd_chk(8'h05, 8'h00);
    chk({7'h00, int_oe}, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_flags;
    fire(1'b0);
    rd_chk(rtc_pkg::ADDR_IRQ_CTRL, 8'h04);
    chk({7'h00, int_oe}, 8'h00);
    h_u.wr(rtc_pkg::ADDR_IRQ_CTRL, 8'h05);
    @(negedge clock);
    chk({7'h00, int_oe}, 8'h01);
    repeat (10) @(negedge clock);
    rd_chk(rtc_pkg::ADDR_IRQ_CTRL, 8'h05);
    fire(1'b1);
    rd_chk(rtc_pkg::ADDR_IRQ_CTRL, 8'h0D);
    h_u.wr(rtc_pkg::ADDR_IRQ_CTRL, 8'h07);
    rd_chk(rtc_pkg::ADDR_IRQ_CTRL, 8'h07);
    chk({7'h00, int_oe}, 8'h01);
    h_u.wr(rtc_pkg::ADDR_IRQ_CTRL, 8'h03);
    rd_chk(rtc_pkg::ADDR_IRQ_CTRL, 8'h03);
    chk({7'h00, int_oe}, 8'h00);
    fire(1'b1);
    chk({7'h00, int_oe}, 8'h01);
    h_u.wr(rtc_pkg::ADDR_IRQ_CTRL, 8'h00);
    rd_chk(rtc_pkg::ADDR_IRQ_CTRL, 8'h00);
    $display("test flags done");
  endtask : t_flags

  task automatic t_pulse;
    h_u.wr(rtc_pkg::ADDR_IRQ_CTRL, 8'h11);
    for (int i = 0; i < 6; i++) begin
      @(negedge clock);
      timer_src     = src_tab[i];
      timer_count_n = n_tab[i];
      fire(1'b0);
      chk({7'h00, int_oe}, 8'h01);
      cnt = 8'h00;
      while (int_oe === 1'b1 && cnt < 8'h28) begin
        cnt++;
        @(negedge clock);
      end
      chk(cnt, w_tab[i]);
      rd_chk(rtc_pkg::ADDR_IRQ_CTRL, 8'h15);
      h_u.wr(rtc_pkg::ADDR_IRQ_CTRL, 8'h11);
    end
    timer_count_n = 8'h00;
    fire(1'b0);
    repeat (3) @(negedge clock);
    rd_chk(rtc_pkg::ADDR_IRQ_CTRL, 8'h11);
    chk({7'h00, int_oe}, 8'h00);
    h_u.wr(rtc_pkg::ADDR_IRQ_CTRL, 8'h13);
    fire(1'b1);
    cnt = 8'h00;
    repeat (20) begin
      if (int_oe === 1'b1) cnt++;
      @(negedge clock);
    end
    chk(cnt, 8'h14);
    chk({7'h00, int_o}, 8'h00);
    h_u.wr(rtc_pkg::ADDR_IRQ_CTRL, 8'h10);
    $display("test pulse done");
  endtask : t_pulse

  task automatic t_integrity;
    h_u.wr(rtc_pkg::ADDR_SECONDS, 8'h45);
    rd_chk(rtc_pkg::ADDR_SECONDS, 8'h45);
    for (int k = 0; k < 2; k++) begin
      @(negedge clock);
      supply_low  = (k == 0);
      osc_stopped = (k != 0);
      repeat (6) @(negedge clock);
      supply_low  = 1'b0;
      osc_stopped = 1'b0;
      repeat (6) @(negedge clock);
      rd_chk(rtc_pkg::ADDR_SECONDS, 8'hC5);
      h_u.wr(rtc_pkg::ADDR_SECONDS, 8'h45);
    end
    $display("test integrity done");
  endtask : t_integrity

  // Reset in mid-run with an alarm interrupt standing and the clock set
  task automatic t_rerst;
    h_u.wr(rtc_pkg::ADDR_IRQ_CTRL, 8'h13);
    fire(1'b1);
    chk({7'h00, int_oe}, 8'h01);
    @(negedge clock);
    rst_b = !rst_b;
    @(negedge clock);
    chk({7'h00, int_oe}, 8'h00);
    repeat (2) @(negedge clock);
    rst_b = !rst_b;
    repeat (3) @(negedge clock);
    rd_chk(rtc_pkg::ADDR_IRQ_CTRL, 8'h00);
    rd_chk(rtc_pkg::ADDR_SECONDS, 8'h80);
    $display("test mid-run reset done");
  endtask : t_rerst

  task automatic t_time;
    h_u.wr(rtc_pkg::ADDR_SECONDS, 8'h59);
    h_u.wr(rtc_pkg::ADDR_MINUTES, 8'h59);
    h_u.wr(rtc_pkg::ADDR_HOURS, 8'h23);
    repeat (60) @(negedge clock);
    rd_chk(rtc_pkg::ADDR_SECONDS, 8'h59);
    // Access drops for exactly one edge, so only the pending second lands
    h_u.hold(1'b0);
    h_u.hold(1'b1);
    rd_chk(rtc_pkg::ADDR_SECONDS, 8'h00);
    rd_chk(rtc_pkg::ADDR_MINUTES, 8'h00);
    rd_chk(rtc_pkg::ADDR_HOURS, 8'h00);
    // Two ticks inside one long access: only one may survive
    h_u.wr(rtc_pkg::ADDR_SECONDS, 8'h10);
    repeat (110) @(negedge clock);
    h_u.hold(1'b0);
    h_u.hold(1'b1);
    rd_chk(rtc_pkg::ADDR_SECONDS, 8'h11);
    $display("test time done");
  endtask : t_time

  initial begin
    mismatches    = 0;
    cmp_count     = 0;
    rst_b         = 1'b0;
    alarm_match   = 1'b0;
    timer_end     = 1'b0;
    supply_low    = 1'b0;
    osc_stopped   = 1'b0;
    timer_src     = rtc_pkg::SRC_4096_HZ;
    timer_count_n = 8'h02;
    repeat (8) @(posedge clock);
    // First tick comes right after reset; held access keeps it pending
    h_u.hold(1'b1);
    rst_b = !rst_b;
    repeat (3) @(negedge clock);
    t_reset();
    t_flags();
    t_pulse();
    t_integrity();
    t_rerst();
    t_time();
    close_out();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    close_out();
  end
endmodule : rtc_irq_time_tb

`default_nettype wire
